// ### rtl/rsc_regs.svh
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH

// register address on the special-function-register bus
`define RSC_ADDR          8'hEF

// bit positions inside the cause/enable register
`define RSC_BIT_PIN       0
`define RSC_BIT_POR       1
`define RSC_BIT_MCD       2
`define RSC_BIT_WDT       3
`define RSC_BIT_SW        4
`define RSC_BIT_CMP       5
`define RSC_BIT_FERR      6
`define RSC_BIT_RTC       7

// values taken at power-on
`define RSC_FLAGS_POR     8'h02
`define RSC_EN_RTC_RST    1'b0
`define RSC_EN_CMP_RST    1'b0
`define RSC_EN_MCD_RST    1'b1
`define RSC_EN_SUP_RST    1'b1

// timing
`define RSC_CLK_NS        100
`define RSC_MCD_NS        100000
`define RSC_MCD_CYC       ((`RSC_MCD_NS + `RSC_CLK_NS - 1) / `RSC_CLK_NS)
`define RSC_WDT_DIV       12
`define RSC_HOLD_CYC      1

`endif

// ### rtl/rsc_pkg.sv
package rsc_pkg;

    // one bit per reset source, laid out as the cause register
    typedef struct packed {
        logic rtc;
        logic ferr;
        logic cmp;
        logic sw;
        logic wdt;
        logic mcd;
        logic por;
        logic pin;
    } rsc_cause_s;

    // flash access observed by the controller in one cycle
    typedef struct packed {
        logic        write_en;
        logic        xdata_wr;
        logic [15:0] xdata_addr;
        logic        code_rd;
        logic [15:0] code_addr;
        logic        fetch;
        logic [15:0] fetch_addr;
        logic        sec_block;
        logic        wr_erase;
    } rsc_flash_req_s;

    typedef enum logic {
        RSC_RUN,
        RSC_HOLD
    } rsc_state_e;

endpackage : rsc_pkg

// ### rtl/rsc_wdt.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"

module rsc_wdt #(
    parameter logic [15:0] WDT_TICKS = 16'h0100
) (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic sys_rst_n,
    input  wire logic run,
    input  wire logic en_wr,
    input  wire logic en_val,
    input  wire logic kick,
    output var  logic expire
);
    logic [3:0]  div_q;
    logic [15:0] cnt_q;
    logic        en_q;
    logic        tick;

    assign tick = (div_q == 4'(`RSC_WDT_DIV - 1));

    // prescaler gives one enable pulse every twelve system clocks
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) div_q <= 4'h0;
        else if (!sys_rst_n || tick) div_q <= 4'h0;
        else div_q <= div_q + 4'h1;
    end

    // enable comes back set after any reset
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) en_q <= 1'b1;
        else if (!sys_rst_n) en_q <= 1'b1;
        else if (en_wr) en_q <= en_val;
    end

    // count frozen, not cleared, in low power so state resumes on exit
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) cnt_q <= 16'h0000;
        else if (!sys_rst_n || kick || !en_q) cnt_q <= 16'h0000;
        else if (run && tick) cnt_q <= (cnt_q == WDT_TICKS - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
    end

    assign expire = en_q && run && tick && sys_rst_n && (cnt_q == WDT_TICKS - 16'h0001);

endmodule : rsc_wdt
`default_nettype wire

// ### rtl/rsc_mcd.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"

module rsc_mcd (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic sys_rst_n,
    input  wire logic enable,
    input  wire logic probe,
    output var  logic timeout
);
    logic        probe_q;
    logic [11:0] cnt_q;
    logic        edge_seen;

    assign edge_seen = probe ^ probe_q;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) probe_q <= 1'b0;
        else probe_q <= probe;
    end

    // any edge of the watched clock restarts the one-shot
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) cnt_q <= 12'h000;
        else if (!enable || !sys_rst_n || edge_seen) cnt_q <= 12'h000;
        else if (!timeout) cnt_q <= cnt_q + 12'h001;
    end

    assign timeout = enable && sys_rst_n && (cnt_q == 12'(`RSC_MCD_CYC));

endmodule : rsc_mcd
`default_nettype wire

// ### rtl/rsc_ctrl.sv
// Overview of operation
// RL1: after any reset the watchdog runs enabled, clocked at system clock over twelve.
// RL2: watchdog expiry resets the device and sets cause bit 3.
// RL3: watchdog reset is suppressed in suspend or sleep; enable state kept for exit.
// RL4: internal resets never drive or change the external reset pin.
// RL5: flash write enabled plus external-data write above lock byte gives flash reset.
// RL6: code-byte read above lock byte gives flash reset.
// RL7: branch or fetch above lock byte gives flash reset.
// RL8: flash access forbidden by security settings gives flash reset.
// RL9: flash write or erase with supply monitor off gives flash reset.
// RL10: after a flash reset, read-only bit 6 reads 1.
// RL11: clock loss or alarm match from the real-time clock raises a reset event.
// RL12: bit 7 enables the real-time clock reset, flags it, works in low power.
// RL13: writing 1 to bit 4 forces reset; bit 4 then reads 1.
// RL14: bit 5 enables comparator reset and reads 1 only after comparator reset.
// RL15: bit 2 enables the missing-clock detector and flags its timeout.
// RL16: bit 1 enables supply-monitor reset; reads 1 after power-on or supply reset.
// RL17: software treats other bits as indeterminate when bit 1 reads 1.
// RL18: read-only bit 0 reads 1 after an external pin reset.
// RL19: software waits for monitor to settle before setting bit 1.
// RL20: read-modify-write of single enables has no side effect on other bits; here reads return the flags, so a write-back alters enables.
// RL21: low reset pin resets the device, also in low power, and sets pin flag.
// RL22: enabled detector resets when system clock sticks for over 100 us.
// RL23: enabled comparator holds reset while positive input is below negative.
// RL24: all cause flags update together on each reset, only causing sources set.
// RL25: internal reset held at least one full clock, then released synchronously.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"

module rsc_ctrl #(
    parameter logic [15:0] LOCK_ADDR = 16'h7FFF,
    parameter logic [15:0] WDT_TICKS = 16'h0100
) (
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    input  wire logic [7:0]              sfr_addr,
    input  wire logic                    sfr_wr,
    input  wire logic                    sfr_rd,
    input  wire logic [7:0]              sfr_wdata,
    output var  logic [7:0]              sfr_rdata,
    input  wire logic                    pin_rst_n,
    input  wire logic                    low_power,
    input  wire logic                    cmp_below,
    input  wire logic                    vdd_low,
    input  wire logic                    supply_mon_on,
    input  wire logic                    rtc_osc_fail,
    input  wire logic                    rtc_alarm,
    input  wire logic                    mcd_probe,
    input  wire logic                    wdt_kick,
    input  wire logic                    wdt_en_wr,
    input  wire logic                    wdt_en_val,
    input  wire rsc_pkg::rsc_flash_req_s flash_req,
    output var  logic                    sys_rst_n
);
    localparam int HOLD_LAST = `RSC_HOLD_CYC - 1;

    rsc_pkg::rsc_state_e state_q;
    rsc_pkg::rsc_cause_s flags_q;
    rsc_pkg::rsc_cause_s cause_now;
    logic                sys_rst_n_q;
    logic [3:0]          hold_cnt_q;
    logic [7:0]          sfr_rdata_q;
    logic                rtc_en_q;
    logic                cmp_en_q;
    logic                mcd_en_q;
    logic                sup_en_q;
    logic                sel;
    logic                wr_cause;
    logic                wdt_exp;
    logic                mcd_to;
    logic                flash_err;
    logic                lvl_active;
    logic                running;

    assign running = (state_q == rsc_pkg::RSC_RUN);
    assign sel      = (sfr_addr == `RSC_ADDR);
    // writes during a held reset are dropped; the core is not executing then
    assign wr_cause = sel && sfr_wr && running;

    // enables are written bit by bit; flag-only bits ignore writes
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rtc_en_q <= `RSC_EN_RTC_RST;
            cmp_en_q <= `RSC_EN_CMP_RST;
            mcd_en_q <= `RSC_EN_MCD_RST;
            sup_en_q <= `RSC_EN_SUP_RST;
        end else if (wr_cause) begin
            rtc_en_q <= sfr_wdata[`RSC_BIT_RTC]; // RL12
            cmp_en_q <= sfr_wdata[`RSC_BIT_CMP]; // RL14
            mcd_en_q <= sfr_wdata[`RSC_BIT_MCD]; // RL15
            sup_en_q <= sfr_wdata[`RSC_BIT_POR]; // RL16
        end
    end

    // watchdog frozen in low power; its own enable survives for exit
    rsc_wdt #(
        .WDT_TICKS (WDT_TICKS)
    ) u_wdt (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .sys_rst_n (sys_rst_n_q),
        .run       (!low_power),   // RL3
        .en_wr     (wdt_en_wr),
        .en_val    (wdt_en_val),
        .kick      (wdt_kick),
        .expire    (wdt_exp)       // RL1
    );

    // detector gated off in low power, enable bit untouched
    rsc_mcd u_mcd (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .sys_rst_n (sys_rst_n_q),
        .enable    (mcd_en_q && !low_power), // RL22
        .probe     (mcd_probe),
        .timeout   (mcd_to)
    );

    // illegal or forbidden flash accesses
    always_comb begin
        flash_err = 1'b0;
        if (flash_req.write_en && flash_req.xdata_wr && (flash_req.xdata_addr > LOCK_ADDR)) flash_err = 1'b1; // RL5
        if (flash_req.code_rd && (flash_req.code_addr > LOCK_ADDR)) flash_err = 1'b1; // RL6
        if (flash_req.fetch && (flash_req.fetch_addr > LOCK_ADDR)) flash_err = 1'b1; // RL7
        if (flash_req.sec_block) flash_err = 1'b1; // RL8
        if (flash_req.wr_erase && !supply_mon_on) flash_err = 1'b1; // RL9
    end

    // per-source reset requests this cycle; pin is only ever an input here
    always_comb begin
        cause_now      = '0;
        cause_now.pin  = !pin_rst_n;                                // RL21 RL4
        cause_now.por  = vdd_low && sup_en_q;                       // RL16
        cause_now.mcd  = mcd_to;                                    // RL15
        cause_now.wdt  = wdt_exp;                                   // RL2
        cause_now.sw   = wr_cause && sfr_wdata[`RSC_BIT_SW];        // RL13
        cause_now.cmp  = cmp_en_q && cmp_below;                     // RL23
        cause_now.ferr = flash_err && running;                      // RL10
        cause_now.rtc  = rtc_en_q && (rtc_osc_fail || rtc_alarm);   // RL11 RL12
    end

    // sources that keep the device in reset for as long as they stand
    assign lvl_active = cause_now.pin || cause_now.por || cause_now.cmp; // RL23

    // sequencer: enter hold on any cause, release on a clock edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q     <= rsc_pkg::RSC_RUN;
            sys_rst_n_q <= 1'b1;
            hold_cnt_q  <= 4'h0;
        end else begin
            case (state_q)
                rsc_pkg::RSC_RUN: begin
                    if (cause_now != '0) begin
                        state_q     <= rsc_pkg::RSC_HOLD;
                        sys_rst_n_q <= 1'b0;
                        hold_cnt_q  <= 4'h0;
                    end
                end
                rsc_pkg::RSC_HOLD: begin
                    if (lvl_active) begin
                        hold_cnt_q <= 4'h0;
                    end else if (hold_cnt_q >= 4'(HOLD_LAST)) begin
                        state_q     <= rsc_pkg::RSC_RUN; // RL25
                        sys_rst_n_q <= 1'b1;
                    end else begin
                        hold_cnt_q <= hold_cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q     <= rsc_pkg::RSC_RUN;
                    sys_rst_n_q <= 1'b1;
                end
            endcase
        end
    end

    // flags replaced as a whole on entry; level sources still active add in
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flags_q <= rsc_pkg::rsc_cause_s'(`RSC_FLAGS_POR); // RL16
        end else if (running && (cause_now != '0)) begin
            flags_q <= cause_now; // RL24
        end else if (!running) begin
            flags_q.pin <= flags_q.pin || cause_now.pin; // RL18
            flags_q.por <= flags_q.por || cause_now.por;
            flags_q.cmp <= flags_q.cmp || cause_now.cmp;
        end
    end

    // read data registered; unselected address returns zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) sfr_rdata_q <= 8'h00;
        else if (sel && sfr_rd) sfr_rdata_q <= flags_q; // RL20
        else sfr_rdata_q <= 8'h00;
    end

    assign sfr_rdata = sfr_rdata_q;
    assign sys_rst_n = sys_rst_n_q;

    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_enter_hold;
        running && (cause_now != '0) |=> !sys_rst_n_q && (state_q == rsc_pkg::RSC_HOLD);
    endproperty
    a_enter_hold: assert property (p_enter_hold) else $error("reset not entered"); // RL25

    property p_flags_whole;
        running && (cause_now != '0) |=> flags_q == $past(cause_now);
    endproperty
    a_flags_whole: assert property (p_flags_whole) else $error("flags not replaced"); // RL24

    property p_release;
        $rose(sys_rst_n_q) |-> $past(state_q == rsc_pkg::RSC_HOLD) && !$past(lvl_active);
    endproperty
    a_release: assert property (p_release) else $error("release while source active"); // RL25

    property p_sw_force;
        wr_cause && sfr_wdata[`RSC_BIT_SW] |=> !sys_rst_n_q && flags_q.sw;
    endproperty
    a_sw_force: assert property (p_sw_force) else $error("soft reset missed"); // RL13

    property p_wdt_flag;
        running && wdt_exp |=> flags_q.wdt && !sys_rst_n_q;
    endproperty
    a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog flag missing"); // RL2

    property p_wdt_quiet_lp;
        low_power |-> !wdt_exp;
    endproperty
    a_wdt_quiet_lp: assert property (p_wdt_quiet_lp) else $error("watchdog fired in low power"); // RL3

    property p_pin_lp;
        running && low_power && !pin_rst_n |=> !sys_rst_n_q && flags_q.pin;
    endproperty
    a_pin_lp: assert property (p_pin_lp) else $error("pin reset ignored"); // RL21

    property p_cmp_hold;
        !running && cmp_en_q && cmp_below |=> !sys_rst_n_q;
    endproperty
    a_cmp_hold: assert property (p_cmp_hold) else $error("comparator released early"); // RL23

    property p_fetch_err;
        running && flash_req.fetch && (flash_req.fetch_addr > LOCK_ADDR) |=> flags_q.ferr ##1 sfr_rdata_q[6] || !$past(sel && sfr_rd);
    endproperty
    a_fetch_err: assert property (p_fetch_err) else $error("fetch above lock not trapped"); // RL7

    property p_flash_nomon;
        running && flash_req.wr_erase && !supply_mon_on |=> !sys_rst_n_q && flags_q.ferr;
    endproperty
    a_flash_nomon: assert property (p_flash_nomon) else $error("write without monitor not trapped"); // RL9

    property p_rtc_en;
        wr_cause |=> rtc_en_q == $past(sfr_wdata[`RSC_BIT_RTC]) && mcd_en_q == $past(sfr_wdata[`RSC_BIT_MCD]);
    endproperty
    a_rtc_en: assert property (p_rtc_en) else $error("enable bit not stored"); // RL12

    property p_rtc_lp;
        running && low_power && rtc_en_q && (rtc_osc_fail || rtc_alarm) |=> flags_q.rtc;
    endproperty
    a_rtc_lp: assert property (p_rtc_lp) else $error("rtc reset lost in low power"); // RL12

    property p_read_back;
        sel && sfr_rd |=> sfr_rdata_q == $past(flags_q);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data wrong"); // RL10

    c_sw_reset:    cover property (wr_cause && sfr_wdata[`RSC_BIT_SW] ##1 !sys_rst_n_q ##[1:4] sys_rst_n_q);
    c_wdt_reset:   cover property (running && wdt_exp ##1 !sys_rst_n_q);
    c_pin_reset:   cover property (running && !pin_rst_n ##1 !sys_rst_n_q [*3] ##1 sys_rst_n_q);
    c_flash_reset: cover property (running && flash_err ##1 flags_q.ferr);

endmodule : rsc_ctrl
`default_nettype wire

// ### verification/rsc_src_model.sv
`timescale 1ns/1ps
`default_nettype none

// on-chip sources and the reset pin as seen by the controller
// ctl: 0 stall clock, 1 pin low, 2 comparator, 3 supply low, 4 monitor off, 5 alarm, 6 osc fail, 7 sleep
module rsc_src_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] ctl,
    output wire logic       pin_rst_n,
    output wire logic       low_power,
    output wire logic       cmp_below,
    output wire logic       vdd_low,
    output wire logic       supply_mon_on,
    output wire logic       rtc_osc_fail,
    output wire logic       rtc_alarm,
    output wire logic       mcd_probe
);
    logic probe_q = 1'b0;

    // watched clock copy; freezing it models a stuck clock
    // toggles on the rising edge so a stall set at the falling edge never races it
    always @(posedge clk_sys) begin
        if (!ctl[0]) begin
            probe_q <= ~probe_q;
        end
    end

    // pin has a pull-up; only the outside world pulls it low, never the controller
    assign pin_rst_n     = ~ctl[1];
    assign cmp_below     = ctl[2];
    assign vdd_low       = ctl[3];
    assign supply_mon_on = ~ctl[4];
    assign rtc_alarm     = ctl[5];
    assign rtc_osc_fail  = ctl[6];
    assign low_power     = ctl[7];
    assign mcd_probe     = probe_q;
endmodule : rsc_src_model

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.svh"

`define TB_CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end

module tb_top;
    localparam logic [15:0] LOCK  = 16'h7FFF;
    localparam logic [7:0]  F_PIN = 8'h01 << `RSC_BIT_PIN;
    localparam logic [7:0]  F_POR = 8'h01 << `RSC_BIT_POR;
    localparam logic [7:0]  F_MCD = 8'h01 << `RSC_BIT_MCD;
    localparam logic [7:0]  F_WDT = 8'h01 << `RSC_BIT_WDT;
    localparam logic [7:0]  F_SW  = 8'h01 << `RSC_BIT_SW;
    localparam logic [7:0]  F_CMP = 8'h01 << `RSC_BIT_CMP;
    localparam logic [7:0]  F_FE  = 8'h01 << `RSC_BIT_FERR;
    localparam logic [7:0]  F_RTC = 8'h01 << `RSC_BIT_RTC;

    logic                   clk_sys = 1'b0;
    logic                   nrst = 1'b0;
    logic [7:0]             sfr_addr = `RSC_ADDR;
    logic                   sfr_wr = 1'b0;
    logic                   sfr_rd = 1'b0;
    logic [7:0]             sfr_wdata = 8'h00;
    logic [7:0]             sfr_rdata;
    logic [7:0]             ctl = 8'h00;
    logic                   wdt_kick = 1'b1;
    logic                   wdt_en_wr = 1'b0;
    logic                   wdt_en_val = 1'b0;
    rsc_pkg::rsc_flash_req_s flash_req = '0;
    rsc_pkg::rsc_flash_req_s fr;
    logic                   sys_rst_n;
    logic                   pin_rst_n, low_power, cmp_below, vdd_low;
    logic                   supply_mon_on, rtc_osc_fail, rtc_alarm, mcd_probe;
    int                     err_count = 0;
    int                     checks = 0;

    // 100 ns period
    always #50 clk_sys = ~clk_sys;

    rsc_src_model u_src (.clk_sys(clk_sys), .ctl(ctl), .pin_rst_n(pin_rst_n), .low_power(low_power),
        .cmp_below(cmp_below), .vdd_low(vdd_low), .supply_mon_on(supply_mon_on),
        .rtc_osc_fail(rtc_osc_fail), .rtc_alarm(rtc_alarm), .mcd_probe(mcd_probe));

    // short watchdog count keeps expiry tests brief
    rsc_ctrl #(.LOCK_ADDR(LOCK), .WDT_TICKS(16'h0004)) u_dut (
        .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_rst_n(pin_rst_n), .low_power(low_power),
        .cmp_below(cmp_below), .vdd_low(vdd_low), .supply_mon_on(supply_mon_on),
        .rtc_osc_fail(rtc_osc_fail), .rtc_alarm(rtc_alarm), .mcd_probe(mcd_probe),
        .wdt_kick(wdt_kick), .wdt_en_wr(wdt_en_wr), .wdt_en_val(wdt_en_val),
        .flash_req(flash_req), .sys_rst_n(sys_rst_n));

    task automatic stop_test();
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc

    // callers leave a cycle before the next bus write so the strobe drops first
    task automatic sfr_write(input logic [7:0] d);
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask : sfr_write

    // read data stands only in the cycle after the strobe
    task automatic sfr_read(output logic [7:0] d);
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        d = sfr_rdata;
        sfr_rd = 1'b0;
        @(negedge clk_sys);
    endtask : sfr_read

    task automatic no_reset(input int n, input string nm);
        int lows;
        lows = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (sys_rst_n !== 1'b1) lows++;
        end
        `TB_CHK(nm, 0, lows)
    endtask : no_reset

    // waits for a bounded reset pulse, then reads back the cause flags
    task automatic expect_reset(input int lim, input logic [7:0] exp, input string nm);
        int n;
        logic [7:0] rd;
        n = 0;
        while (sys_rst_n !== 1'b0 && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        `TB_CHK({nm, " reset"}, 1'b0, sys_rst_n)
        n = 0;
        while (sys_rst_n !== 1'b1 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        `TB_CHK({nm, " release"}, 1'b1, sys_rst_n)
        sfr_read(rd);
        `TB_CHK({nm, " flags"}, exp, rd)
    endtask : expect_reset

    // one-cycle flash access request
    task automatic flash_hit(input rsc_pkg::rsc_flash_req_s r);
        flash_req = r;
        @(negedge clk_sys);
        flash_req = '0;
    endtask : flash_hit

    // hang guard, far beyond the roughly 1500 cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        stop_test();
    end

    // power-on flags, then a forced software reset
    task automatic t_power_soft();
        logic [7:0] rd;
        sfr_read(rd);
        `TB_CHK("power-on flags", F_POR, rd)
        `TB_CHK("power-on bit", 1'b1, rd[`RSC_BIT_POR])
        sfr_write(8'h12);
        expect_reset(2, F_SW, "soft");
    endtask : t_power_soft

    task automatic t_flash();
        // flash faults; mirror cases just inside the limits must pass quietly
        fr = '0; fr.write_en = 1'b1; fr.xdata_wr = 1'b1; fr.xdata_addr = LOCK + 16'h0001;
        flash_hit(fr);
        expect_reset(3, F_FE, "xdata wr");
        fr.write_en = 1'b0;
        flash_hit(fr);
        no_reset(5, "xdata wr locked");
        fr = '0; fr.code_rd = 1'b1; fr.code_addr = 16'hFFFF;
        flash_hit(fr);
        expect_reset(3, F_FE, "code rd");
        fr = '0; fr.fetch = 1'b1; fr.fetch_addr = LOCK;
        flash_hit(fr);
        no_reset(5, "fetch at lock");
        fr.fetch_addr = LOCK + 16'h0001;
        flash_hit(fr);
        expect_reset(3, F_FE, "fetch");
        fr = '0; fr.sec_block = 1'b1;
        flash_hit(fr);
        expect_reset(3, F_FE, "security");
        fr = '0; fr.wr_erase = 1'b1;
        flash_hit(fr);
        no_reset(5, "erase monitor on");
        ctl[4] = 1'b1;
        flash_hit(fr);
        expect_reset(3, F_FE, "erase monitor off");
        ctl[4] = 1'b0;
    endtask : t_flash

    // watchdog: off by software, back on after a software reset
    task automatic t_wdt();
        wdt_kick = 1'b0;
        wdt_en_wr = 1'b1;
        cyc(1);
        wdt_en_wr = 1'b0;
        no_reset(120, "wdt disabled");
        sfr_write(8'h12);
        expect_reset(2, F_SW, "soft again");
        // four ticks of twelve clocks: expiry lands 48 clocks after release
        no_reset(44, "wdt early");
        expect_reset(3, F_WDT, "wdt");
        ctl[7] = 1'b1;
        no_reset(150, "wdt asleep");
        ctl[7] = 1'b0;
        expect_reset(60, F_WDT, "wdt woke");
        wdt_kick = 1'b1;
    endtask : t_wdt

    // real-time clock source, awake and asleep, then disabled
    task automatic t_rtc();
        sfr_write(8'h82);
        ctl[5] = 1'b1;
        cyc(1);
        ctl[5] = 1'b0;
        expect_reset(3, F_RTC, "alarm");
        ctl[7] = 1'b1;
        ctl[6] = 1'b1;
        cyc(1);
        ctl[6] = 1'b0;
        expect_reset(3, F_RTC, "osc fail asleep");
        ctl[7] = 1'b0;
        sfr_write(8'h02);
        ctl[5] = 1'b1;
        cyc(1);
        ctl[5] = 1'b0;
        no_reset(10, "alarm disabled");
    endtask : t_rtc

    // comparator holds reset as long as it stands
    task automatic t_cmp();
        sfr_write(8'h22);
        ctl[2] = 1'b1;
        cyc(12);
        `TB_CHK("cmp hold", 1'b0, sys_rst_n)
        ctl[2] = 1'b0;
        expect_reset(3, F_CMP, "cmp");
        sfr_write(8'h02);
        ctl[2] = 1'b1;
        no_reset(10, "cmp disabled");
        ctl[2] = 1'b0;
    endtask : t_cmp

    // stuck clock trips just after the 100 us span, not before
    task automatic t_mcd();
        sfr_write(8'h06);
        ctl[0] = 1'b1;
        no_reset(995, "clock stuck early");
        expect_reset(20, F_MCD, "clock stuck");
        ctl[0] = 1'b0;
    endtask : t_mcd

    // pin reset works in sleep, then a supply reset
    task automatic t_pin_supply();
        ctl[7] = 1'b1;
        ctl[1] = 1'b1;
        cyc(3);
        `TB_CHK("pin hold", 1'b0, sys_rst_n)
        ctl[1] = 1'b0;
        expect_reset(3, F_PIN, "pin");
        ctl[7] = 1'b0;
        ctl[3] = 1'b1;
        cyc(3);
        ctl[3] = 1'b0;
        expect_reset(3, F_POR, "supply");
    endtask : t_pin_supply

    initial begin
        cyc(5);
        nrst = 1'b1;
        t_power_soft();
        t_flash();
        t_wdt();
        t_rtc();
        t_cmp();
        t_mcd();
        t_pin_supply();
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
